//--- inc/fbp_defs.svh
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH

// bus timing in 100 MHz cycles
`define FBP_CLK_PERIOD_NS   10
`define FBP_WE_PULSE_NS     40
`define FBP_WE_CYC          ((`FBP_WE_PULSE_NS + `FBP_CLK_PERIOD_NS - 1) / `FBP_CLK_PERIOD_NS)
`define FBP_RD_ACCESS_NS    110
`define FBP_RD_CYC          ((`FBP_RD_ACCESS_NS + `FBP_CLK_PERIOD_NS - 1) / `FBP_CLK_PERIOD_NS)
`define FBP_UNLOCK_GAP_NS   1000
`define FBP_UNLOCK_GAP_CYC  ((`FBP_UNLOCK_GAP_NS + `FBP_CLK_PERIOD_NS - 1) / `FBP_CLK_PERIOD_NS)

// unlock cycle addresses (x16) and data
`define FBP_ADDR_UNLK1      16'h0555
`define FBP_ADDR_UNLK2      16'h02AA
`define FBP_DATA_UNLK1      8'hAA
`define FBP_DATA_UNLK2      8'h55

// command set entry and command codes
`define FBP_CODE_LOCKREG    8'h40
`define FBP_CODE_PASSWORD   8'h60
`define FBP_CODE_NONVOL     8'hC0
`define FBP_CODE_LOCKBIT    8'h50
`define FBP_CODE_VOLATILE   8'hE0
`define FBP_CODE_EXTBLOCK   8'h88
`define FBP_CODE_PROGRAM    8'hA0
`define FBP_CODE_EXIT1      8'h90
`define FBP_CODE_EXIT2      8'h00
`define FBP_CODE_CLRALL1    8'h80
`define FBP_CODE_CLRALL2    8'h30
`define FBP_CODE_UNLOCK1    8'h25
`define FBP_CODE_UNLOCK2    8'h03
`define FBP_CODE_UNLOCKGO   8'h29

// protection bit data values
`define FBP_BIT_PROTECT     8'h00
`define FBP_BIT_UNPROTECT   8'h01

// password layout
`define FBP_PWD_WORDS       4
`define FBP_PWD_BYTES       8

`endif

//--- inc/fbp_pkg.sv
package fbp_pkg;

  // host command opcodes at the user port
  typedef enum logic [3:0] {
    OP_ENTER_LOCKREG,  // enter lock register set
    OP_ENTER_PASSWORD, // enter password set
    OP_ENTER_NONVOL,   // enter nonvolatile set
    OP_ENTER_LOCKBIT,  // enter lock bit set
    OP_ENTER_VOLATILE, // enter volatile set
    OP_ENTER_EXTBLOCK, // enter extended block
    OP_EXIT,           // exit protection set
    OP_EXIT_EXTBLOCK,  // exit extended block
    OP_PROGRAM,        // A0 + address/data in set mode
    OP_READ,           // plain read cycle
    OP_CLEAR_ALL,      // clear all nonvolatile bits
    OP_UNLOCK,         // unlock password (4 words)
    OP_PWD_PROGRAM,    // program all password words
    OP_PWD_READ        // read all password words
  } fbp_op_t;

  // one bus cycle in a sequence
  typedef struct packed {
    logic        isRead;
    logic [25:0] addr;
    logic [15:0] data;
  } fbp_cycle_t;

endpackage

//--- hdl/fbp_bus_cycle.sv
`timescale 1ns/10ps
`include "fbp_defs.svh"

// one asynchronous bus cycle on the flash pins
module fbp_bus_cycle #(
  parameter int ADDR_W = 26   // flash address width
) (
  input  wire logic              clock,     // system clock
  input  wire logic              resetn,    // sync reset, active low
  input  wire logic              start,     // begin a cycle
  input  wire logic              isRead,    // read instead of write
  input  wire logic [ADDR_W-1:0] addr,      // cycle address
  input  wire logic [15:0]       wdata,     // write data
  input  wire logic [15:0]       dqIn,      // data pins, synchronised
  output logic                   busy,      // cycle in progress
  output logic                   done,      // cycle finished pulse
  output logic [15:0]            rdata,     // captured read data
  output logic [ADDR_W-1:0]      flashAddr, // address pins
  output logic [15:0]            dqOut,     // data pins out
  output logic                   dqOe,      // data pins drive enable
  output logic                   ceN,       // chip enable
  output logic                   oeN,       // output enable
  output logic                   weN        // write enable
);

  initial begin
    if (ADDR_W < 16 || ADDR_W > 26) $error("ADDR_W out of range");
  end

  localparam int CYC = (`FBP_RD_CYC > `FBP_WE_CYC) ? `FBP_RD_CYC + 3
                                                  : `FBP_WE_CYC + 3;

  typedef struct packed {
    logic              active;
    logic              rd;
    logic [7:0]        cnt;
    logic              done;
    logic [15:0]       rdata;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
  } fbp_bc_state_t;

  fbp_bc_state_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (!s_reg.active) begin
      if (start) begin
        s_next.active = 1'b1;
        s_next.rd     = isRead;
        s_next.addr   = addr;
        s_next.wdata  = wdata;
        s_next.cnt    = 8'h00;
      end
    end else begin
      s_next.cnt = s_reg.cnt + 8'h01;
      // sample late: dqIn lags the pins by two flops
      if (s_reg.rd && s_reg.cnt == 8'(CYC - 1)) s_next.rdata = dqIn;
      if (s_reg.cnt == 8'(CYC)) begin
        s_next.active = 1'b0;
        s_next.done   = 1'b1;
      end
    end
    if (!resetn) s_next = '0;
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  // strobe held inside address/data setup and hold margins
  logic strobe;
  assign strobe    = s_reg.active && s_reg.cnt != 8'h00
                     && s_reg.cnt < 8'(CYC - 2);
  assign busy      = s_reg.active;
  assign done      = s_reg.done;
  assign rdata     = s_reg.rdata;
  assign flashAddr = s_reg.addr;
  assign dqOut     = s_reg.wdata;
  assign dqOe      = s_reg.active && !s_reg.rd;
  assign ceN       = !s_reg.active;
  assign oeN       = !(s_reg.active && s_reg.rd);
  assign weN       = !(strobe && !s_reg.rd);

endmodule // fbp_bus_cycle

//--- hdl/fbp_host_ctrl.sv
`timescale 1ns/10ps
`include "fbp_defs.svh"

module fbp_host_ctrl #(
  parameter int ADDR_W = 26   // flash word address width
) (
  input  wire logic                 clock,     // 100 MHz system clock
  input  wire logic                 resetn,    // sync reset, active low
  input  wire logic                 cmdValid,  // command request
  input  wire fbp_pkg::fbp_op_t     cmdOp,     // command opcode
  input  wire logic [ADDR_W-1:0]    cmdAddr,   // block or word address
  input  wire logic [63:0]          cmdData,   // data or password
  input  wire logic                 wpLevel,   // desired write-protect level
  output logic                      cmdReady,  // idle, may take command
  output logic                      rspValid,  // command finished pulse
  output logic [63:0]               rspData,   // read result
  output logic                      rspRefused,// command refused pulse
  output logic [ADDR_W-1:0]         flashAddr, // flash address pins
  output logic [15:0]               dqOut,     // data pins out
  output logic                      dqOe,      // data pins drive enable
  input  wire logic [15:0]          dqIn,      // data pins in
  output logic                      ceN,       // chip enable, low active
  output logic                      oeN,       // output enable, low active
  output logic                      weN,       // write enable, low active
  output logic                      wpN,       // write-protect pin
  output logic                      rstN       // flash reset pin
);

  initial begin
    if (ADDR_W < 16 || ADDR_W > 26) $error("ADDR_W out of range");
  end

  localparam int GAP_W = $clog2(`FBP_UNLOCK_GAP_CYC + 1);

  typedef enum logic [2:0] {
    ST_IDLE, ST_BUILD, ST_ISSUE, ST_WAIT, ST_DONE
  } fbp_state_t;

  typedef enum logic [2:0] {
    MD_READ, MD_LOCKREG, MD_PASSWORD, MD_NONVOL, MD_LOCKBIT,
    MD_VOLATILE, MD_EXTBLOCK
  } fbp_mode_t;

  typedef struct packed {
    fbp_state_t         st;
    fbp_mode_t          mode;
    fbp_pkg::fbp_op_t   op;
    logic [ADDR_W-1:0]  addr;
    logic [63:0]        data;
    logic [3:0]         idx;
    logic [3:0]         total;
    logic [63:0]        rd;
    logic [GAP_W-1:0]   gap;
    logic               refused;
    logic               rspV;
    logic               rspR;
    logic [15:0]        dqS1;
    logic [15:0]        dqS2;
    logic               wp;
    logic               rstOut;
  } fbp_host_state_t;

  fbp_host_state_t s_reg, s_next;

  logic              bcStart;
  logic              bcBusy;
  logic              bcDone;
  logic [15:0]       bcRdata;
  fbp_pkg::fbp_cycle_t cyc;

  // sequence table: cycle idx of the current operation
  always_comb begin
    cyc = '{isRead: 1'b0, addr: 26'h0, data: 16'h0000};
    if (s_reg.idx == 4'h0) begin
      cyc.addr = 26'(`FBP_ADDR_UNLK1);
      cyc.data = {8'h00, `FBP_DATA_UNLK1};
    end else if (s_reg.idx == 4'h1) begin
      cyc.addr = 26'(`FBP_ADDR_UNLK2);
      cyc.data = {8'h00, `FBP_DATA_UNLK2};
    end
    unique case (s_reg.op)
      fbp_pkg::OP_ENTER_LOCKREG, fbp_pkg::OP_ENTER_PASSWORD,
      fbp_pkg::OP_ENTER_NONVOL, fbp_pkg::OP_ENTER_LOCKBIT,
      fbp_pkg::OP_ENTER_VOLATILE, fbp_pkg::OP_ENTER_EXTBLOCK: begin
        if (s_reg.idx == 4'h2) begin
          cyc.addr = 26'(`FBP_ADDR_UNLK1);
          unique case (s_reg.op)
            fbp_pkg::OP_ENTER_LOCKREG:  cyc.data[7:0] = `FBP_CODE_LOCKREG;
            fbp_pkg::OP_ENTER_PASSWORD: cyc.data[7:0] = `FBP_CODE_PASSWORD;
            fbp_pkg::OP_ENTER_NONVOL:   cyc.data[7:0] = `FBP_CODE_NONVOL;
            fbp_pkg::OP_ENTER_LOCKBIT:  cyc.data[7:0] = `FBP_CODE_LOCKBIT;
            fbp_pkg::OP_ENTER_VOLATILE: cyc.data[7:0] = `FBP_CODE_VOLATILE;
            default:                    cyc.data[7:0] = `FBP_CODE_EXTBLOCK;
          endcase
        end
      end
      fbp_pkg::OP_EXIT_EXTBLOCK: begin
        if (s_reg.idx == 4'h2) begin
          cyc.addr = 26'(`FBP_ADDR_UNLK1);
          cyc.data = {8'h00, `FBP_CODE_EXIT1};
        end else if (s_reg.idx == 4'h3) begin
          cyc.data = {8'h00, `FBP_CODE_EXIT2};
        end
      end
      fbp_pkg::OP_EXIT: begin
        cyc.addr = 26'h0;
        cyc.data = {8'h00, (s_reg.idx == 4'h0) ? `FBP_CODE_EXIT1
                                               : `FBP_CODE_EXIT2};
      end
      // program cycle carries 00/01 or value
      fbp_pkg::OP_PROGRAM: begin
        cyc.addr = (s_reg.idx == 4'h0) ? 26'h0 : 26'(s_reg.addr);
        cyc.data = (s_reg.idx == 4'h0) ? {8'h00, `FBP_CODE_PROGRAM}
                                       : s_reg.data[15:0];
      end
      fbp_pkg::OP_READ: begin
        cyc.isRead = 1'b1;
        cyc.addr   = 26'(s_reg.addr);
        cyc.data   = 16'h0000;
      end
      fbp_pkg::OP_CLEAR_ALL: begin
        cyc.addr = 26'h0;
        cyc.data = {8'h00, (s_reg.idx == 4'h0) ? `FBP_CODE_CLRALL1
                                               : `FBP_CODE_CLRALL2};
      end
      // 25h, 03h, four password words, 29h
      fbp_pkg::OP_UNLOCK: begin
        cyc.addr = 26'h0;
        if (s_reg.idx == 4'h0) cyc.data = {8'h00, `FBP_CODE_UNLOCK1};
        else if (s_reg.idx == 4'h1) cyc.data = {8'h00, `FBP_CODE_UNLOCK2};
        else if (s_reg.idx < 4'h6) begin
          cyc.addr = 26'(s_reg.idx - 4'h2);
          cyc.data = s_reg.data[16*(s_reg.idx-4'h2) +: 16];
        end else cyc.data = {8'h00, `FBP_CODE_UNLOCKGO};
      end
      // A0h then word n at address n
      fbp_pkg::OP_PWD_PROGRAM: begin
        cyc.addr = s_reg.idx[0] ? 26'(s_reg.idx[2:1]) : 26'h0;
        cyc.data = s_reg.idx[0] ? s_reg.data[16*s_reg.idx[2:1] +: 16]
                                : {8'h00, `FBP_CODE_PROGRAM};
      end
      fbp_pkg::OP_PWD_READ: begin
        cyc.isRead = 1'b1;
        cyc.addr   = 26'(s_reg.idx[1:0]);
      end
    endcase
  end

  function automatic logic [3:0] seqLen(input fbp_pkg::fbp_op_t op);
    unique case (op)
      fbp_pkg::OP_EXIT_EXTBLOCK, fbp_pkg::OP_PWD_READ: seqLen = 4'h4;
      fbp_pkg::OP_EXIT, fbp_pkg::OP_PROGRAM,
      fbp_pkg::OP_CLEAR_ALL:                           seqLen = 4'h2;
      fbp_pkg::OP_READ:                                seqLen = 4'h1;
      fbp_pkg::OP_UNLOCK:                              seqLen = 4'h7;
      fbp_pkg::OP_PWD_PROGRAM:                         seqLen = 4'h8;
      default:                                         seqLen = 4'h3;
    endcase
  endfunction

  // refuse commands that the current mode would not accept
  function automatic logic allowed(input fbp_pkg::fbp_op_t op,
                                   input fbp_mode_t md,
                                   input logic [ADDR_W-1:0] a);
    unique case (op)
      fbp_pkg::OP_ENTER_LOCKREG, fbp_pkg::OP_ENTER_PASSWORD,
      fbp_pkg::OP_ENTER_NONVOL, fbp_pkg::OP_ENTER_LOCKBIT,
      fbp_pkg::OP_ENTER_VOLATILE,
      fbp_pkg::OP_ENTER_EXTBLOCK: allowed = (md == MD_READ);
      fbp_pkg::OP_EXIT: allowed = (md != MD_READ && md != MD_EXTBLOCK);
      fbp_pkg::OP_EXIT_EXTBLOCK: allowed = (md == MD_EXTBLOCK);
      fbp_pkg::OP_PROGRAM: allowed = (md != MD_READ && md != MD_PASSWORD);
      fbp_pkg::OP_READ: allowed = 1'b1;
      fbp_pkg::OP_CLEAR_ALL: allowed = (md == MD_NONVOL);
      // password commands only in password set
      fbp_pkg::OP_UNLOCK, fbp_pkg::OP_PWD_PROGRAM,
      fbp_pkg::OP_PWD_READ: allowed = (md == MD_PASSWORD);
      // two opcode values are unused; refuse them
      default: allowed = 1'b0;
    endcase
    // block 0 closed in set modes except extended block, lock register and lock bit
    if (md != MD_READ && md != MD_EXTBLOCK && a[ADDR_W-1:16] == '0
        && (op == fbp_pkg::OP_READ || op == fbp_pkg::OP_PROGRAM)
        && md != MD_LOCKREG && md != MD_LOCKBIT) allowed = 1'b0;
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.rspV = 1'b0;
    s_next.rspR = 1'b0;
    s_next.dqS1 = dqIn;
    s_next.dqS2 = s_reg.dqS1;
    s_next.wp   = wpLevel;
    s_next.rstOut = 1'b1;
    if (s_reg.gap != '0) s_next.gap = s_reg.gap - GAP_W'(1);
    unique case (s_reg.st)
      ST_IDLE: begin
        if (cmdValid) begin
          s_next.op    = cmdOp;
          s_next.addr  = cmdAddr;
          s_next.data  = cmdData;
          s_next.idx   = 4'h0;
          s_next.total = seqLen(cmdOp);
          s_next.rd    = 64'h0;
          s_next.st    = ST_BUILD;
          s_next.refused = !allowed(cmdOp, s_reg.mode, cmdAddr);
        end
      end
      ST_BUILD: begin
        if (s_reg.refused) begin
          s_next.st   = ST_IDLE;
          s_next.rspR = 1'b1;
        end else if (s_reg.op == fbp_pkg::OP_UNLOCK && s_reg.gap != '0) begin
          s_next.st = ST_BUILD;
        end else begin
          s_next.st = ST_ISSUE;
        end
      end
      ST_ISSUE: s_next.st = ST_WAIT;
      ST_WAIT: begin
        if (bcDone) begin
          if (cyc.isRead) s_next.rd[16*s_reg.idx[1:0] +: 16] = bcRdata;
          if (s_reg.idx + 4'h1 == s_reg.total) s_next.st = ST_DONE;
          else begin
            s_next.idx = s_reg.idx + 4'h1;
            s_next.st  = ST_ISSUE;
          end
        end
      end
      ST_DONE: begin
        s_next.st   = ST_IDLE;
        s_next.rspV = 1'b1;
        if (s_reg.op == fbp_pkg::OP_UNLOCK)
          s_next.gap = GAP_W'(`FBP_UNLOCK_GAP_CYC);
        unique case (s_reg.op)
          fbp_pkg::OP_ENTER_LOCKREG:  s_next.mode = MD_LOCKREG;
          fbp_pkg::OP_ENTER_PASSWORD: s_next.mode = MD_PASSWORD;
          fbp_pkg::OP_ENTER_NONVOL:   s_next.mode = MD_NONVOL;
          fbp_pkg::OP_ENTER_LOCKBIT:  s_next.mode = MD_LOCKBIT;
          fbp_pkg::OP_ENTER_VOLATILE: s_next.mode = MD_VOLATILE;
          fbp_pkg::OP_ENTER_EXTBLOCK: s_next.mode = MD_EXTBLOCK;
          fbp_pkg::OP_EXIT, fbp_pkg::OP_EXIT_EXTBLOCK:
                                      s_next.mode = MD_READ;
          default:                    s_next.mode = s_reg.mode;
        endcase
      end
      default: s_next.st = ST_IDLE;
    endcase
    if (!resetn) begin
      s_next = '0;
      s_next.wp = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  assign bcStart = (s_reg.st == ST_ISSUE);

  fbp_bus_cycle #(
    .ADDR_W (ADDR_W)
  ) u_cycle (
    .clock     (clock),
    .resetn    (resetn),
    .start     (bcStart),
    .isRead    (cyc.isRead),
    .addr      (cyc.addr[ADDR_W-1:0]),
    .wdata     (cyc.data),
    .dqIn      (s_reg.dqS2),
    .busy      (bcBusy),
    .done      (bcDone),
    .rdata     (bcRdata),
    .flashAddr (flashAddr),
    .dqOut     (dqOut),
    .dqOe      (dqOe),
    .ceN       (ceN),
    .oeN       (oeN),
    .weN       (weN)
  );

  assign cmdReady   = (s_reg.st == ST_IDLE) && !bcBusy;
  assign rspValid   = s_reg.rspV;
  assign rspRefused = s_reg.rspR;
  assign rspData    = s_reg.rd;
  assign wpN        = s_reg.wp;
  // flash reset low during our reset restores volatile bits
  assign rstN       = s_reg.rstOut;

endmodule // fbp_host_ctrl

//--- test/fbp_flash_model.sv
`timescale 1ns/10ps
// behavioural flash, commands decoded on write-enable rise
module fbp_flash_model (
  input  logic [25:0] flashAddr, // address pins
  input  logic [15:0] dqOut,     // host data
  input  logic        ceN,       // chip enable
  input  logic        oeN,       // output enable
  input  logic        weN,       // write enable
  input  logic        rstN,      // hardware reset
  output logic [15:0] dqIn       // data to host
);
  logic [7:0]    mode;
  logic [1:0]    step;
  logic [1:0]    pend;
  logic [15:0]   lockReg;
  logic [15:0]   rd;
  logic [15:0]   lastRd;
  logic [15:0]   pwd [4];
  logic [15:0]   ext [128];
  logic [1023:0] nvBits;
  logic [1023:0] volBits;
  logic          lockBit;
  wire  [9:0]    blk = flashAddr[25:16];

  initial begin
    nvBits = '1;
    lockReg = '1;
    lastRd = '0;
    foreach (pwd[i]) pwd[i] = '1;
    foreach (ext[i]) ext[i] = '1;
  end

  always @(posedge weN or negedge rstN) begin
    if (!rstN) begin
      {mode, step, pend} = '0;
      volBits = '1;
      lockBit = 1'b1;
    end else if (!ceN) begin
      if (pend == 2'd1) begin
        case (mode)
          8'h40: lockReg = lockReg & dqOut;
          8'h60: pwd[flashAddr[1:0]] = pwd[flashAddr[1:0]] & dqOut;
          8'hC0: if (lockBit && !dqOut[0]) nvBits[blk] = 1'b0;
          8'h50: lockBit = 1'b0;
          8'hE0: volBits[blk] = dqOut[0];
          8'h88: if (lockReg[0]) ext[flashAddr[6:0]] &= dqOut;
          default: ;
        endcase
        pend = 2'd0;
      end else if (pend == 2'd2) begin
        if (dqOut[7:0] == 8'h00) mode = 8'h00;
        pend = 2'd0;
      end else if (pend == 2'd3) begin
        if (dqOut[7:0] == 8'h30 && lockBit) nvBits = '1;
        pend = 2'd0;
      end else if (step == 2'd2) begin
        step = 2'd0;
        if (dqOut[7:0] == 8'hA0) pend = 2'd1;
        else if (dqOut[7:0] == 8'h90) pend = 2'd2;
        else mode = dqOut[7:0];
      end else if (step == 2'd1) begin
        step = (flashAddr[15:0] == 16'h02AA && dqOut[7:0] == 8'h55) ? 2 : 0;
      end else if (flashAddr[15:0] == 16'h0555 && dqOut[7:0] == 8'hAA) begin
        step = 2'd1;
      end else if (dqOut[7:0] == 8'hA0) pend = 2'd1;
      else if (dqOut[7:0] == 8'h90) pend = 2'd2;
      else if (dqOut[7:0] == 8'h80) pend = 2'd3;
    end
  end

  always_comb begin
    case (mode)
      8'h40: rd = lockReg;
      8'h60: rd = pwd[flashAddr[1:0]];
      8'hC0: rd = {15'h0000, nvBits[blk]};
      8'h50: rd = {15'h0000, lockBit};
      8'hE0: rd = {15'h0000, volBits[blk]};
      8'h88: rd = ext[flashAddr[6:0]];
      default: rd = flashAddr[15:0] ^ 16'hA5A5;
    endcase
  end
  always @(ceN or oeN or rd) if (!ceN && !oeN) lastRd = rd;
  // released bus shows the inverse, so stale data never matches
  assign dqIn = (!ceN && !oeN) ? rd : ~lastRd;
endmodule // fbp_flash_model

//--- test/fbp_host_ctrl_sva.sv
`timescale 1ns/10ps
module fbp_host_ctrl_sva #(
  parameter int ADDR_W = 26 // word address width
) (
  input logic clock,      // clock
  input logic resetn,     // sync reset
  input logic cmdValid,   // request
  input logic wpLevel,    // protect level
  input logic cmdReady,   // idle
  input logic rspValid,   // done pulse
  input logic rspRefused, // refusal pulse
  input logic [ADDR_W-1:0] flashAddr, // address pins
  input logic [15:0] dqOut, // data out
  input logic dqOe,       // drive enable
  input logic ceN,        // chip enable
  input logic oeN,        // output enable
  input logic weN,        // write enable
  input logic wpN,        // protect pin
  input logic rstN        // flash reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_take; cmdValid && cmdReady; endsequence
  sequence s_wpulse;
    (!weN && !ceN && dqOe && oeN && $stable(flashAddr) && $stable(dqOut)) [*8];
  endsequence
  a_reset_pins: assert property (disable iff (1'b0)
    !resetn |=> !rstN && ceN && weN && !dqOe) else $error("reset pins");
  a_wp_follow: assert property ($past(resetn) |-> wpN == $past(wpLevel))
    else $error("write protect pin");
  a_refuse_quiet: assert property (rspRefused |->
    $past(cmdValid && cmdReady, 2) && ceN && $past(ceN)) else $error("refuse");
  a_resp_once: assert property (rspValid |-> !rspRefused ##1
    !rspValid && !rspRefused) else $error("response pulse");
  a_take_bounded: assert property (s_take |-> ##[2:700]
    (rspValid || rspRefused)) else $error("no response");
  a_take_busy: assert property (s_take |=> !cmdReady)
    else $error("ready after take");
  a_write_pulse: assert property ($fell(weN) |-> s_wpulse)
    else $error("write cycle");
  a_read_safe: assert property (!oeN |-> !dqOe && weN && !ceN)
    else $error("read cycle");
endmodule // fbp_host_ctrl_sva

//--- test/testbench.sv
`timescale 1ns/10ps
`define CHECK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); \
  end \
end
module testbench;
  logic             clock = 1'b0;
  logic             resetn, cmdValid, wpLevel;
  fbp_pkg::fbp_op_t cmdOp;
  logic [25:0]      cmdAddr, flashAddr;
  logic [63:0]      cmdData, rspData;
  logic             cmdReady, rspValid, rspRefused, dqOe;
  logic             ceN, oeN, weN, wpN, rstN;
  logic [15:0]      dqOut, dqIn;
  int               checks = 0;
  int               fail_count = 0;
  time              t0;

  fbp_host_ctrl #(.ADDR_W(26)) dut (
    .clock(clock), .resetn(resetn), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .wpLevel(wpLevel),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
    .rspRefused(rspRefused), .flashAddr(flashAddr), .dqOut(dqOut),
    .dqOe(dqOe), .dqIn(dqIn), .ceN(ceN), .oeN(oeN), .weN(weN),
    .wpN(wpN), .rstN(rstN));
  fbp_flash_model flash (.flashAddr(flashAddr), .dqOut(dqOut), .ceN(ceN),
    .oeN(oeN), .weN(weN), .rstN(rstN), .dqIn(dqIn));

  always #5 clock = ~clock;

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmd(input fbp_pkg::fbp_op_t op, input logic [25:0] a,
                     input logic [63:0] d, input logic refuse);
    int n;
    @(negedge clock);
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    cmdValid = 1'b1;
    for (n = 0; cmdReady !== 1'b1 && n < 1000; n++) @(negedge clock);
    if (n >= 1000) begin
      fail_count++;
      summarize();
    end
    // held through the taking edge
    @(negedge clock);
    cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && rspRefused !== 1'b1 && n < 1000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 1000) begin
      fail_count++;
      summarize();
    end else `CHECK("refusal", refuse, rspRefused)
  endtask

  task automatic rdChk(input logic [25:0] a, input logic [15:0] e);
    cmd(fbp_pkg::OP_READ, a, '0, 1'b0);
    `CHECK("read data", e, rspData[15:0])
  endtask

  initial begin
    {resetn, cmdValid, cmdAddr, cmdData} = '0;
    cmdOp = fbp_pkg::OP_READ;
    wpLevel = 1'b1;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    cmd(fbp_pkg::OP_EXIT, '0, '0, 1);
    cmd(fbp_pkg::OP_PROGRAM, '0, '0, 1);
    cmd(fbp_pkg::OP_ENTER_LOCKREG, '0, '0, 0);
    cmd(fbp_pkg::OP_PROGRAM, '0, 64'h5A5B, 0);
    rdChk('0, 16'h5A5B);
    cmd(fbp_pkg::OP_EXIT, '0, '0, 0);
    rdChk(26'h30, 16'h0030 ^ 16'hA5A5);
    $display("test lock register done");
    cmd(fbp_pkg::OP_PWD_READ, '0, '0, 1);
    cmd(fbp_pkg::OP_ENTER_PASSWORD, '0, '0, 0);
    cmd(fbp_pkg::OP_PWD_READ, '0, '0, 0);
    `CHECK("blank password", {64{1'b1}}, rspData)
    cmd(fbp_pkg::OP_PWD_PROGRAM, '0, 64'h0123456789ABCDEF, 0);
    cmd(fbp_pkg::OP_PWD_READ, '0, '0, 0);
    `CHECK("password", 64'h0123456789ABCDEF, rspData)
    cmd(fbp_pkg::OP_UNLOCK, '0, 64'h0123456789ABCDEF, 0);
    t0 = $time;
    cmd(fbp_pkg::OP_UNLOCK, '0, 64'h0123456789ABCDEF, 0);
    `CHECK("unlock spacing", 1'b1, ($time - t0) >= 64'd2000)
    cmd(fbp_pkg::OP_EXIT, '0, '0, 0);
    $display("test password done");
    cmd(fbp_pkg::OP_ENTER_NONVOL, '0, '0, 0);
    cmd(fbp_pkg::OP_READ, '0, '0, 1);
    cmd(fbp_pkg::OP_PROGRAM, 26'h30000, '0, 0);
    rdChk(26'h30000, 16'h0000);
    cmd(fbp_pkg::OP_CLEAR_ALL, '0, '0, 0);
    rdChk(26'h30000, 16'h0001);
    cmd(fbp_pkg::OP_PROGRAM, 26'h30000, '0, 0);
    cmd(fbp_pkg::OP_EXIT, '0, '0, 0);
    cmd(fbp_pkg::OP_ENTER_LOCKBIT, '0, '0, 0);
    cmd(fbp_pkg::OP_PROGRAM, '0, '0, 0);
    rdChk('0, 16'h0000);
    cmd(fbp_pkg::OP_EXIT, '0, '0, 0);
    cmd(fbp_pkg::OP_ENTER_NONVOL, '0, '0, 0);
    cmd(fbp_pkg::OP_CLEAR_ALL, '0, '0, 0);
    rdChk(26'h30000, 16'h0000);
    cmd(fbp_pkg::OP_EXIT, '0, '0, 0);
    $display("test nonvolatile done");
    @(negedge clock);
    wpLevel = 1'b0;
    cmd(fbp_pkg::OP_ENTER_VOLATILE, '0, '0, 0);
    cmd(fbp_pkg::OP_CLEAR_ALL, '0, '0, 1);
    cmd(fbp_pkg::OP_PROGRAM, 26'h50000, 64'h0, 0);
    cmd(fbp_pkg::OP_PROGRAM, 26'h60000, 64'h0, 0);
    rdChk(26'h50000, 16'h0000);
    cmd(fbp_pkg::OP_PROGRAM, 26'h50000, 64'h1, 0);
    rdChk(26'h50000, 16'h0001);
    rdChk(26'h60000, 16'h0000);
    @(negedge clock);
    wpLevel = 1'b1;
    resetn = 1'b0;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    cmd(fbp_pkg::OP_ENTER_VOLATILE, '0, '0, 0);
    rdChk(26'h60000, 16'h0001);
    cmd(fbp_pkg::OP_EXIT, '0, '0, 0);
    $display("test volatile done");
    cmd(fbp_pkg::OP_ENTER_EXTBLOCK, '0, '0, 0);
    cmd(fbp_pkg::OP_EXIT, '0, '0, 1);
    cmd(fbp_pkg::OP_PROGRAM, 26'h9, 64'h00F0, 0);
    cmd(fbp_pkg::OP_PROGRAM, 26'h9, 64'hFF0F, 0);
    rdChk(26'h9, 16'h0000);
    cmd(fbp_pkg::OP_EXIT_EXTBLOCK, '0, '0, 0);
    rdChk(26'h9, 16'h0009 ^ 16'hA5A5);
    $display("test extended block done");
    summarize();
  end
endmodule // testbench

bind fbp_host_ctrl fbp_host_ctrl_sva #(.ADDR_W(ADDR_W)) sva (
  .clock(clock), .resetn(resetn), .cmdValid(cmdValid), .wpLevel(wpLevel),
  .cmdReady(cmdReady), .rspValid(rspValid), .rspRefused(rspRefused),
  .flashAddr(flashAddr), .dqOut(dqOut), .dqOe(dqOe), .ceN(ceN),
  .oeN(oeN), .weN(weN), .wpN(wpN), .rstN(rstN));
